// ===== src/fwi_pkg.sv
// constants for the fault and wake-up interrupt controller
package fwi_pkg;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h04;
  localparam logic [4:0] ADDR_IRQ_FLAGS  = 5'h05;
  localparam logic [4:0] ADDR_SYS_STATUS = 5'h07;
  localparam logic [4:0] ADDR_WAKE_MASK  = 5'h08;
  localparam int BIT_OC   = 1;
  localparam int BIT_HV   = 2;
  localparam int BIT_UV   = 3;
  localparam int BIT_OT   = 4;
  localparam int BIT_EDGE = 5;
  localparam int BIT_WDG  = 0;
  localparam int BIT_LVR  = 6;
  localparam logic [7:0] FLAG_MASK   = 8'h3E;
  localparam logic [7:0] ENABLE_MASK = 8'h3E;
  localparam logic [7:0] WAKE_MASK_BITS = 8'h61;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PERIOD_MIN_NS = 50000;
  localparam int unsigned PERIOD_MAX_NS = 10000000;
  localparam int unsigned LIMIT_DUTY_PCT = 50;
  localparam logic [1:0] SYNC_AGREE = 2'h3;
  localparam logic [1:0] SYNC_FALL  = 2'h0;
  typedef enum logic [0:0] {
    FWI_RUN  = 1'b0,
    FWI_STOP = 1'b1
  } fwi_mode_t;
endpackage

// ===== src/fwi_ctrl.sv
// fault and wake-up interrupt controller of the analog control die
`timescale 1ns/1ns
// How it works
// - pull shared reset low while any internal reset source is active
// - low reset line brings the controller side to its startup state
// - reset line is open-drain with pull-up, tied to controller reset
// - interrupt output is open-drain, signals error or wake events
// - current-limit input gives period only; duty made internally
// - five interrupt sources, each enabled by register write
// - every reset clears all interrupt enables
// - under-voltage sets its flag, interrupt when enabled
// - under-voltage switches off only the high-side transistors
// - over-voltage sets its flag, interrupt when enabled
// - over-voltage switches off only the high-side transistors
// - over-temperature sets its flag, interrupt when enabled
// - stop mode disables voltage and temperature detection
// - enabled bus falling edge raises an interrupt
// - in stop mode an enabled bus edge with its wake-mask bit set starts full wake-up
// - enabled over-current on any bridge or supply raises interrupt
// - masked wake events restart main regulator and wake controller
// - each bus falling edge sets the bus-edge flag
// - writing one clears bus-edge flag, zero leaves it
// - any reset clears the bus-edge flag
// - enable register at 0x04 holds enables in bits 5..1, reset zero
// - writing one clears fault flags only once condition is gone
// - over-current flag clears by writing one in system status
module fwi_ctrl #(
  parameter int unsigned LIMIT_DIV = 1
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       REG_WR_I,
  input  wire logic [4:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       STOP_MODE_I,
  input  wire logic       UNDERVOLT_I,
  input  wire logic       OVERVOLT_I,
  input  wire logic       OVERTEMP_I,
  input  wire logic       BUS_RX_I,
  input  wire logic [3:0] BRIDGE_OVERCURRENT_I,
  input  wire logic       SUPPLY_OVERCURRENT_I,
  input  wire logic       WDG_WAKE_I,
  input  wire logic       WDG_RESET_I,
  input  wire logic       LOW_VOLTAGE_RESET_I,
  input  wire logic       RST_N_I,
  output logic            RST_N_O,
  output logic            RST_N_OE_N_O,
  output logic            IRQ_N_O,
  output logic            IRQ_N_OE_N_O,
  input  wire logic       LIMIT_PERIOD_I,
  output logic            LIMIT_PULSE_O,
  output logic            HIGH_SIDE_OFF_O,
  output logic            REGULATOR_ON_O,
  output logic            MCU_WAKE_O,
  output logic            DIE_RESET_O
);

  localparam logic [7:0] RESET_VALUE_C = fwi_pkg::RESET_VALUE;
  localparam int unsigned LIMIT_DUTY_C = fwi_pkg::LIMIT_DUTY_PCT;

  typedef struct packed {
    logic [2:0]  bus_sync;
    logic [2:0]  per_sync;
    logic [2:0]  rst_sync;
    logic        bus_state;
    logic        per_state;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  wake_mask;
    logic [7:0]  rdata;
    logic [31:0] per_cnt;
    logic [31:0] per_len;
    logic        pulse;
    logic        wake;
  } fwi_state_t;

  fwi_state_t st_ff;
  fwi_state_t nxt_st;

  logic       [7:0] set_vec;
  logic       [7:0] hold_vec;
  logic       [7:0] clr_vec;
  logic             bus_fall;
  logic             per_rise;
  logic             any_oc;
  logic             internal_rst;
  logic             active;

  always_comb begin
    nxt_st = st_ff;
    active = (st_ff.flags & st_ff.enables) != RESET_VALUE_C;
    nxt_st.bus_sync = {st_ff.bus_sync[1:0], BUS_RX_I};
    nxt_st.per_sync = {st_ff.per_sync[1:0], LIMIT_PERIOD_I};
    nxt_st.rst_sync = {st_ff.rst_sync[1:0], RST_N_I};
    // only the second and third stages are looked at
    if (st_ff.bus_sync[2:1] == fwi_pkg::SYNC_AGREE ||
        st_ff.bus_sync[2:1] == fwi_pkg::SYNC_FALL) begin
      nxt_st.bus_state = st_ff.bus_sync[1];
    end
    if (st_ff.per_sync[2:1] == fwi_pkg::SYNC_AGREE ||
        st_ff.per_sync[2:1] == fwi_pkg::SYNC_FALL) begin
      nxt_st.per_state = st_ff.per_sync[1];
    end
    bus_fall = st_ff.bus_state && !nxt_st.bus_state;
    per_rise = !st_ff.per_state && nxt_st.per_state;
    any_oc = (|BRIDGE_OVERCURRENT_I) | SUPPLY_OVERCURRENT_I;
    set_vec = RESET_VALUE_C;
    hold_vec = RESET_VALUE_C;
    // detectors gated off in stop mode
    if (!STOP_MODE_I) begin
      set_vec[fwi_pkg::BIT_UV] = UNDERVOLT_I;
      set_vec[fwi_pkg::BIT_HV] = OVERVOLT_I;
      set_vec[fwi_pkg::BIT_OT] = OVERTEMP_I;
    end
    set_vec[fwi_pkg::BIT_EDGE] = bus_fall;
    set_vec[fwi_pkg::BIT_OC] = any_oc;
    hold_vec = set_vec;
    clr_vec = RESET_VALUE_C;
    if (REG_WR_I && REG_ADDR_I == fwi_pkg::ADDR_IRQ_FLAGS) begin
      // writing one clears; a live condition keeps the flag
      clr_vec[fwi_pkg::BIT_EDGE] = REG_WDATA_I[fwi_pkg::BIT_EDGE];
      clr_vec[fwi_pkg::BIT_OT] = REG_WDATA_I[fwi_pkg::BIT_OT];
      clr_vec[fwi_pkg::BIT_UV] = REG_WDATA_I[fwi_pkg::BIT_UV];
      clr_vec[fwi_pkg::BIT_HV] = REG_WDATA_I[fwi_pkg::BIT_HV];
    end
    if (REG_WR_I && REG_ADDR_I == fwi_pkg::ADDR_SYS_STATUS) begin
      clr_vec[fwi_pkg::BIT_OC] = REG_WDATA_I[fwi_pkg::BIT_OC];
    end
    // set wins over clear so no event is lost
    nxt_st.flags = ((st_ff.flags & ~clr_vec) | hold_vec)
                   & fwi_pkg::FLAG_MASK;
    if (REG_WR_I && REG_ADDR_I == fwi_pkg::ADDR_IRQ_ENABLE) begin
      nxt_st.enables = REG_WDATA_I & fwi_pkg::ENABLE_MASK;
    end
    if (REG_WR_I && REG_ADDR_I == fwi_pkg::ADDR_WAKE_MASK) begin
      nxt_st.wake_mask = REG_WDATA_I & fwi_pkg::WAKE_MASK_BITS;
    end
    case (REG_ADDR_I)
      fwi_pkg::ADDR_IRQ_ENABLE: nxt_st.rdata = st_ff.enables;
      fwi_pkg::ADDR_IRQ_FLAGS:  nxt_st.rdata = st_ff.flags;
      fwi_pkg::ADDR_SYS_STATUS: begin
        nxt_st.rdata = RESET_VALUE_C;
        nxt_st.rdata[fwi_pkg::BIT_OC] = st_ff.flags[fwi_pkg::BIT_OC];
      end
      fwi_pkg::ADDR_WAKE_MASK:  nxt_st.rdata = st_ff.wake_mask;
      default:                  nxt_st.rdata = RESET_VALUE_C;
    endcase
    // period measured between rising edges; duty generated here
    if (per_rise) begin
      nxt_st.per_len = st_ff.per_cnt;
      nxt_st.per_cnt = 32'h0000_0000;
    end else if (st_ff.per_cnt != 32'hFFFF_FFFF) begin
      nxt_st.per_cnt = st_ff.per_cnt + 32'h0000_0001;
    end
    // a period outside the recommended band still works, only coarser
    nxt_st.pulse = (st_ff.per_len != 32'h0000_0000) &&
                   (st_ff.per_cnt < (st_ff.per_len / 32'(100 / LIMIT_DUTY_C)));
    // wake-up only from stop and only with the event's mask bit set
    nxt_st.wake = st_ff.wake;
    if (STOP_MODE_I && ((bus_fall && st_ff.enables[fwi_pkg::BIT_EDGE] &&
        st_ff.wake_mask[fwi_pkg::BIT_EDGE]) ||
        (WDG_WAKE_I && st_ff.wake_mask[fwi_pkg::BIT_WDG]) ||
        (LOW_VOLTAGE_RESET_I && st_ff.wake_mask[fwi_pkg::BIT_LVR]))) begin
      nxt_st.wake = 1'b1;
    end else if (!STOP_MODE_I) begin
      nxt_st.wake = 1'b0;
    end
    // flags, enables and wake state all cleared by any reset,
    // including the controller holding the shared wire low
    if (RST_I || internal_rst || DIE_RESET_O) begin
      nxt_st.flags = RESET_VALUE_C;
      nxt_st.enables = RESET_VALUE_C;
      nxt_st.wake_mask = RESET_VALUE_C;
      nxt_st.wake = 1'b0;
    end
  end

  // the wire seen low is kept out of the pull, else it would latch low
  assign internal_rst = WDG_RESET_I | LOW_VOLTAGE_RESET_I;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      st_ff <= '0;
      st_ff.bus_sync <= 3'h7;
      st_ff.per_sync <= 3'h0;
      st_ff.rst_sync <= 3'h7;
      st_ff.bus_state <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA_O = st_ff.rdata;
  // open drain: output value fixed low, enable low means driving
  assign RST_N_O = 1'b0;
  assign RST_N_OE_N_O = !(internal_rst | RST_I);
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE_N_O = !(active || st_ff.wake);
  assign LIMIT_PULSE_O = st_ff.pulse;
  assign HIGH_SIDE_OFF_O = st_ff.flags[fwi_pkg::BIT_UV] |
                           st_ff.flags[fwi_pkg::BIT_HV];
  assign REGULATOR_ON_O = !STOP_MODE_I || st_ff.wake;
  assign MCU_WAKE_O = st_ff.wake;
  assign DIE_RESET_O = (st_ff.rst_sync[2:1] == fwi_pkg::SYNC_FALL);

endmodule

// ===== testbench/fwi_ctrl_checker.sv
// port-level assertions for the fault and wake-up interrupt controller
`timescale 1ns/1ns
module fwi_ctrl_checker (
  input wire logic       CORE_CLK_I,
  input wire logic       RST_I,
  input wire logic [4:0] REG_ADDR_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       STOP_MODE_I,
  input wire logic       UNDERVOLT_I,
  input wire logic       WDG_RESET_I,
  input wire logic       LOW_VOLTAGE_RESET_I,
  input wire logic       RST_N_I,
  input wire logic       RST_N_O,
  input wire logic       RST_N_OE_N_O,
  input wire logic       IRQ_N_O,
  input wire logic       HIGH_SIDE_OFF_O,
  input wire logic       MCU_WAKE_O,
  input wire logic       DIE_RESET_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // long enough to pass any synchroniser of three stages
  sequence wire_low_s;
    !RST_N_I [*5];
  endsequence
  sequence quiet_stop_s;
    STOP_MODE_I && $past(STOP_MODE_I) && !HIGH_SIDE_OFF_O;
  endsequence
  reset_pull_a: assert property (
    (WDG_RESET_I || LOW_VOLTAGE_RESET_I) |-> !RST_N_OE_N_O) else $error("no pull");
  wire_seen_a: assert property (
    wire_low_s |-> DIE_RESET_O) else $error("reset wire low not seen");
  rst_level_a: assert property (
    RST_N_O == 1'b0) else $error("reset driver not low");
  irq_level_a: assert property (
    IRQ_N_O == 1'b0) else $error("interrupt driver not low");
  uv_cut_a: assert property (
    (!STOP_MODE_I && UNDERVOLT_I && !WDG_RESET_I && !LOW_VOLTAGE_RESET_I &&
     !DIE_RESET_O) |=> HIGH_SIDE_OFF_O) else $error("no cut");
  stop_quiet_a: assert property (
    quiet_stop_s |=> !HIGH_SIDE_OFF_O) else $error("fault seen in stop");
  wake_run_a: assert property (
    (!STOP_MODE_I && !$past(STOP_MODE_I)) |=> !MCU_WAKE_O) else $error("wake");
  unmapped_rd_a: assert property (
    (REG_ADDR_I == 5'h1F) |=> (REG_RDATA_O == 8'h00)) else $error("unmapped");
  en_bits_a: assert property (
    (REG_ADDR_I == fwi_pkg::ADDR_IRQ_ENABLE) |=>
    ((REG_RDATA_O & ~fwi_pkg::ENABLE_MASK) == 8'h00)) else $error("enable bits");
endmodule

// ===== testbench/fwi_mcu_model.sv
// controller side: pull-ups on the shared reset and interrupt wires
`timescale 1ns/1ns
module fwi_mcu_model (
  input  wire logic drv_rst_i,
  input  wire logic rst_oe_n_i,
  input  wire logic rst_val_i,
  input  wire logic irq_oe_n_i,
  input  wire logic irq_val_i,
  output logic      rst_wire_o,
  output logic      irq_wire_o
);
  // any low driver wins, otherwise the pull-up sets the level
  assign rst_wire_o = (rst_oe_n_i | rst_val_i) & ~drv_rst_i;
  assign irq_wire_o = irq_oe_n_i | irq_val_i;
endmodule

// ===== testbench/fwi_ctrl_test.sv
// self-checking bench for the fault and wake-up interrupt controller
`timescale 1ns/1ns
module fwi_ctrl_test;
  logic       CORE_CLK_I = 1'b0;
  logic       RST_I = 1'b1;
  logic       REG_WR_I = 1'b0;
  logic [4:0] REG_ADDR_I = 5'h00;
  logic [7:0] REG_WDATA_I = 8'h00;
  logic       STOP_MODE_I = 1'b0;
  logic [2:0] flt = 3'h0;
  logic       BUS_RX_I = 1'b1;
  logic [3:0] BRIDGE_OVERCURRENT_I = 4'h0;
  logic       WDG_RESET_I = 1'b0;
  logic       SUPPLY_OVERCURRENT_I = 1'b0, WDG_WAKE_I = 1'b0;
  logic       LOW_VOLTAGE_RESET_I = 1'b0, LIMIT_PERIOD_I = 1'b0;
  logic       mcu_rst = 1'b0;
  logic [7:0] REG_RDATA_O, m;
  logic       UNDERVOLT_I, OVERVOLT_I, OVERTEMP_I, RST_N_I, RST_N_O, irq_w;
  logic       RST_N_OE_N_O, IRQ_N_O, IRQ_N_OE_N_O, LIMIT_PULSE_O, DIE_RESET_O;
  logic       HIGH_SIDE_OFF_O, REGULATOR_ON_O, MCU_WAKE_O;
  int         n_fail = 0, cmp_count = 0, cyc = 0;
  int         hi_cnt = 0;
  logic       meas = 1'b0;
  assign {OVERTEMP_I, OVERVOLT_I, UNDERVOLT_I} = flt;
  fwi_ctrl dut_u (.*);
  fwi_mcu_model mcu_u (.drv_rst_i(mcu_rst), .rst_oe_n_i(RST_N_OE_N_O),
    .rst_val_i(RST_N_O), .irq_oe_n_i(IRQ_N_OE_N_O), .irq_val_i(IRQ_N_O),
    .rst_wire_o(RST_N_I), .irq_wire_o(irq_w));
  always #4 CORE_CLK_I = ~CORE_CLK_I;
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    @(posedge CORE_CLK_I);
    REG_WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge CORE_CLK_I);
    REG_ADDR_I <= a;
    repeat (2) @(posedge CORE_CLK_I);
    #1 chk8(REG_RDATA_O, e);
  endtask
  // pulse output is counted on the falling clock edge, away from the launching edge
  always @(negedge CORE_CLK_I) begin
    if (meas && LIMIT_PULSE_O) begin
      hi_cnt <= hi_cnt + 1;
    end
  end
  // a hang costs a mismatch rather than an endless run
  always @(posedge CORE_CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    rd(fwi_pkg::ADDR_IRQ_ENABLE, 8'h00);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(fwi_pkg::ADDR_IRQ_ENABLE, 8'hFF);
    rd(fwi_pkg::ADDR_IRQ_ENABLE, 8'h3E);
    rd(5'h1F, 8'h00);
    $display("register test done");
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h08 : (i == 1) ? 8'h04 : 8'h10;
      // first pass runs with every enable cleared
      wr(fwi_pkg::ADDR_IRQ_ENABLE, (i == 0) ? 8'h00 : m);
      flt <= 3'h1 << i;
      repeat (3) @(posedge CORE_CLK_I);
      #1 chk1(HIGH_SIDE_OFF_O, i < 2);
      chk1(irq_w, i == 0);
      rd(fwi_pkg::ADDR_IRQ_FLAGS, m);
      wr(fwi_pkg::ADDR_IRQ_FLAGS, m);
      rd(fwi_pkg::ADDR_IRQ_FLAGS, m);
      flt <= 3'h0;
      wr(fwi_pkg::ADDR_IRQ_FLAGS, m);
      rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
      chk1(irq_w, 1'b1);
    end
    wr(fwi_pkg::ADDR_IRQ_ENABLE, 8'h22);
    BRIDGE_OVERCURRENT_I <= 4'h8;
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h02);
    chk1(irq_w, 1'b0);
    BRIDGE_OVERCURRENT_I <= 4'h0;
    wr(fwi_pkg::ADDR_SYS_STATUS, 8'h02);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    BUS_RX_I <= 1'b0;
    repeat (6) @(posedge CORE_CLK_I);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h20);
    chk1(irq_w, 1'b0);
    wr(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h20);
    wr(fwi_pkg::ADDR_IRQ_FLAGS, 8'h20);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    $display("fault and edge test done");
    // 6400 cycles is 51.2 us, inside the recommended band
    for (int p = 0; p < 3; p++) begin
      meas <= (p == 2);
      LIMIT_PERIOD_I <= 1'b1;
      repeat (3200) @(posedge CORE_CLK_I);
      LIMIT_PERIOD_I <= 1'b0;
      repeat (3200) @(posedge CORE_CLK_I);
    end
    meas <= 1'b0;
    @(posedge CORE_CLK_I);
    chk1((hi_cnt >= 3196) && (hi_cnt <= 3204), 1'b1);
    $display("current-limit pulse test done");
    STOP_MODE_I <= 1'b1;
    BUS_RX_I <= 1'b1;
    flt <= 3'h7;
    wr(fwi_pkg::ADDR_WAKE_MASK, 8'h20);
    rd(fwi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    BUS_RX_I <= 1'b0;
    repeat (6) @(posedge CORE_CLK_I);
    #1 chk1(MCU_WAKE_O, 1'b1);
    chk1(REGULATOR_ON_O, 1'b1);
    @(posedge CORE_CLK_I);
    STOP_MODE_I <= 1'b0;
    flt <= 3'h0;
    WDG_RESET_I <= 1'b1;
    @(posedge CORE_CLK_I);
    #1 chk1(RST_N_I, 1'b0);
    @(posedge CORE_CLK_I);
    WDG_RESET_I <= 1'b0;
    mcu_rst <= 1'b1;
    repeat (6) @(posedge CORE_CLK_I);
    #1 chk1(DIE_RESET_O, 1'b1);
    rd(fwi_pkg::ADDR_IRQ_ENABLE, 8'h00);
    $display("stop and reset test done");
    close_out();
  end
endmodule
bind fwi_ctrl fwi_ctrl_checker chk_u (.*);
